// [hdl/cbw_pkg.sv]
// constants for the cardbus bridge window and bus-number decode
package cbw_pkg;
  typedef logic [31:0] cbw_word_t;
  typedef logic [7:0] cbw_byte_t;

  // configuration byte offsets
  localparam logic [7:0] OFF_PRIMARY_BUS = 8'h18;
  localparam logic [7:0] OFF_SECONDARY_BUS = 8'h19;
  localparam logic [7:0] OFF_SUBORDINATE_BUS = 8'h1A;
  localparam logic [7:0] OFF_CARD_LATENCY = 8'h1B;
  localparam logic [7:0] OFF_MEM_BASE [2] = '{8'h1C, 8'h24};
  localparam logic [7:0] OFF_MEM_LIMIT [2] = '{8'h20, 8'h28};
  localparam logic [7:0] OFF_IO_BASE [2] = '{8'h2C, 8'h34};
  localparam logic [7:0] OFF_IO_LIMIT [2] = '{8'h30, 8'h38};

  // byte lanes inside the bus-number dword
  localparam int LANE_PRIMARY = 0;
  localparam int LANE_SECONDARY = 1;
  localparam int LANE_SUBORDINATE = 2;
  localparam int LANE_LATENCY = 3;

  // reset values
  localparam cbw_byte_t BUS_NUM_RESET = 8'h00;
  localparam cbw_byte_t LATENCY_RESET = 8'h00;
  localparam cbw_word_t WINDOW_RESET = 32'h0000_0000;

  // writable bit masks and fixed low fills
  localparam cbw_word_t MEM_WR_MASK = 32'hFFFF_F000;
  localparam cbw_word_t MEM_LIMIT_FILL = 32'h0000_0FFF;
  localparam cbw_word_t IO_WR_MASK = 32'h0000_FFFC;
  localparam cbw_word_t IO_LIMIT_FILL = 32'h0000_0003;
  localparam cbw_word_t READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    LAT_IDLE,
    LAT_COUNT,
    LAT_EXPIRED
  } cbw_lat_state_t;
endpackage

// [hdl/cbw_win_if.sv]
// carries one address window between the decode top and a comparator
`timescale 1ns/1ps
`default_nettype none
interface cbw_win_if;
  logic [31:0] low_addr;
  logic [31:0] high_addr;
  logic [31:0] probe_addr;
  logic enable;
  logic hit;

  modport owner (output low_addr, output high_addr, output probe_addr, output enable,
    input hit);
  modport compare (input low_addr, input high_addr, input probe_addr, input enable,
    output hit);
endinterface
`default_nettype wire

// [hdl/cbw_win_cmp.sv]
// inclusive range comparator for one address window
`timescale 1ns/1ps
`default_nettype none
module cbw_win_cmp (
  cbw_win_if.compare win
);
  // inside when base <= addr <= limit, only if the window is enabled
  assign win.hit = win.enable && (win.probe_addr >= win.low_addr) &&
    (win.probe_addr <= win.high_addr);
endmodule
`default_nettype wire

// [hdl/cbw_window_decode.sv]
// bus-number, latency-timer and window decode of a cardbus bridge
`timescale 1ns/1ps
`default_nettype none
module cbw_window_decode import cbw_pkg::*; #(
  parameter int LAT_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // configuration cycle forwarding
  input wire logic fwd_req,
  input wire logic [7:0] fwd_bus,
  output logic fwd_valid,
  output logic fwd_claim,
  output logic fwd_type0,
  output logic fwd_own_bus,
  // memory decode
  input wire logic mem_req,
  input wire logic mem_from_card,
  input wire logic [31:0] mem_addr,
  output logic mem_valid,
  output logic mem_forward,
  output logic [1:0] mem_win,
  output logic mem_prefetch,
  // io decode
  input wire logic io_req,
  input wire logic io_from_card,
  input wire logic [31:0] io_addr,
  output logic io_valid,
  output logic io_forward,
  output logic [1:0] io_win,
  // control bits held elsewhere
  input wire logic [1:0] win_prefetch,
  input wire logic io_base_sel,
  input wire logic io_limit_sel,
  // cardbus initiator tracking
  input wire logic cb_tick,
  input wire logic cb_frame_start,
  input wire logic cb_busy,
  input wire logic cb_data_done,
  output logic cb_lat_expired,
  output logic cb_terminate
);
  localparam int NWIN = 2;

  cbw_byte_t prim_reg, prim_next;
  cbw_byte_t sec_reg, sec_next;
  cbw_byte_t sub_reg, sub_next;
  logic [LAT_W-1:0] lat_reg, lat_next;
  cbw_word_t mem_base_reg [NWIN];
  cbw_word_t mem_base_next [NWIN];
  cbw_word_t mem_lim_reg [NWIN];
  cbw_word_t mem_lim_next [NWIN];
  cbw_word_t io_base_reg [NWIN];
  cbw_word_t io_base_next [NWIN];
  cbw_word_t io_lim_reg [NWIN];
  cbw_word_t io_lim_next [NWIN];
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [5:0] dw;
  logic [31:0] be_mask;

  function automatic cbw_word_t merge(input cbw_word_t old, input cbw_word_t wd,
    input cbw_word_t m);
    merge = (old & ~m) | (wd & m);
  endfunction

  assign dw = cfg_addr[7:2];
  assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // register writes
  always_comb begin
    prim_next = prim_reg;
    sec_next = sec_reg;
    sub_next = sub_reg;
    lat_next = lat_reg;
    mem_base_next = mem_base_reg;
    mem_lim_next = mem_lim_reg;
    io_base_next = io_base_reg;
    io_lim_next = io_lim_reg;
    if (cfg_wr && dw == OFF_PRIMARY_BUS[7:2]) begin
      if (cfg_be[LANE_PRIMARY]) begin
        prim_next = cfg_wdata[8*LANE_PRIMARY +: 8];
      end
      if (cfg_be[LANE_SECONDARY]) begin
        sec_next = cfg_wdata[8*LANE_SECONDARY +: 8];
      end
      if (cfg_be[LANE_SUBORDINATE]) begin
        sub_next = cfg_wdata[8*LANE_SUBORDINATE +: 8];
      end
      if (cfg_be[LANE_LATENCY]) begin
        lat_next = cfg_wdata[8*LANE_LATENCY +: LAT_W];
      end
    end
    for (int k = 0; k < NWIN; k++) begin
      if (cfg_wr && dw == OFF_MEM_BASE[k][7:2]) begin
        mem_base_next[k] = merge(mem_base_reg[k], cfg_wdata, be_mask & MEM_WR_MASK);
      end
      if (cfg_wr && dw == OFF_MEM_LIMIT[k][7:2]) begin
        mem_lim_next[k] = merge(mem_lim_reg[k], cfg_wdata, be_mask & MEM_WR_MASK);
      end
      if (cfg_wr && dw == OFF_IO_BASE[k][7:2]) begin
        io_base_next[k] = merge(io_base_reg[k], cfg_wdata, be_mask & IO_WR_MASK);
      end
      if (cfg_wr && dw == OFF_IO_LIMIT[k][7:2]) begin
        io_lim_next[k] = merge(io_lim_reg[k], cfg_wdata, be_mask & IO_WR_MASK);
      end
    end
  end

  // register reads, answered one cycle after the strobe
  always_comb begin
    rdata_next = READ_ZERO;
    rvalid_next = cfg_rd;
    if (cfg_rd) begin
      if (dw == OFF_PRIMARY_BUS[7:2]) begin
        rdata_next[8*LANE_PRIMARY +: 8] = prim_reg;
        rdata_next[8*LANE_SECONDARY +: 8] = sec_reg;
        rdata_next[8*LANE_SUBORDINATE +: 8] = sub_reg;
        rdata_next[8*LANE_LATENCY +: LAT_W] = lat_reg;
      end
      for (int k = 0; k < NWIN; k++) begin
        if (dw == OFF_MEM_BASE[k][7:2]) begin
          rdata_next = mem_base_reg[k] & MEM_WR_MASK;
        end
        if (dw == OFF_MEM_LIMIT[k][7:2]) begin
          rdata_next = mem_lim_reg[k] & MEM_WR_MASK;
        end
        if (dw == OFF_IO_BASE[k][7:2]) begin
          rdata_next = (io_base_reg[k] & IO_WR_MASK) | {31'h0000_0000, io_base_sel};
        end
        if (dw == OFF_IO_LIMIT[k][7:2]) begin
          rdata_next = (io_lim_reg[k] & IO_WR_MASK) | {31'h0000_0000, io_limit_sel};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prim_reg <= BUS_NUM_RESET;
      sec_reg <= BUS_NUM_RESET;
      sub_reg <= BUS_NUM_RESET;
      lat_reg <= LAT_W'(LATENCY_RESET);
      for (int k = 0; k < NWIN; k++) begin
        mem_base_reg[k] <= WINDOW_RESET;
        mem_lim_reg[k] <= WINDOW_RESET;
        io_base_reg[k] <= WINDOW_RESET;
        io_lim_reg[k] <= WINDOW_RESET;
      end
      rdata_reg <= READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      prim_reg <= prim_next;
      sec_reg <= sec_next;
      sub_reg <= sub_next;
      lat_reg <= lat_next;
      mem_base_reg <= mem_base_next;
      mem_lim_reg <= mem_lim_next;
      io_base_reg <= io_base_next;
      io_lim_reg <= io_lim_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;

  // window comparators
  logic [NWIN-1:0] mem_hit;
  logic [NWIN-1:0] io_hit;

  generate
    for (genvar k = 0; k < NWIN; k++) begin : g_win
      cbw_win_if mem_if ();
      cbw_win_if io_if ();
      assign mem_if.low_addr = mem_base_reg[k] & MEM_WR_MASK;
      assign mem_if.high_addr = (mem_lim_reg[k] & MEM_WR_MASK) | MEM_LIMIT_FILL;
      assign mem_if.probe_addr = mem_addr;
      assign mem_if.enable = |(mem_base_reg[k] & MEM_WR_MASK) ||
        |(mem_lim_reg[k] & MEM_WR_MASK);
      assign mem_hit[k] = mem_if.hit;
      assign io_if.low_addr = io_base_reg[k] & IO_WR_MASK;
      assign io_if.high_addr = (io_lim_reg[k] & IO_WR_MASK) | IO_LIMIT_FILL;
      assign io_if.probe_addr = io_addr;
      assign io_if.enable = |(io_base_reg[k] & IO_WR_MASK) ||
        |(io_lim_reg[k] & IO_WR_MASK);
      assign io_hit[k] = io_if.hit;
      cbw_win_cmp u_mem_cmp (
        .win(mem_if)
      );
      cbw_win_cmp u_io_cmp (
        .win(io_if)
      );
    end
  endgenerate

  // decode answers
  logic fwd_valid_reg, fwd_valid_next;
  logic fwd_claim_reg, fwd_claim_next;
  logic fwd_type0_reg, fwd_type0_next;
  logic fwd_own_reg, fwd_own_next;
  logic mem_valid_reg, mem_valid_next;
  logic mem_fwd_reg, mem_fwd_next;
  logic [1:0] mem_win_reg, mem_win_next;
  logic mem_pf_reg, mem_pf_next;
  logic io_valid_reg, io_valid_next;
  logic io_fwd_reg, io_fwd_next;
  logic [1:0] io_win_reg, io_win_next;

  always_comb begin
    fwd_valid_next = fwd_req;
    fwd_own_next = fwd_req && (fwd_bus == prim_reg);
    fwd_claim_next = fwd_req && (fwd_bus != prim_reg) && (fwd_bus >= sec_reg) &&
      (fwd_bus <= sub_reg);
    fwd_type0_next = fwd_claim_next && (fwd_bus == sec_reg);
    mem_valid_next = mem_req;
    mem_win_next = mem_req ? mem_hit : 2'h0;
    // from pci: inside goes down; from card: outside goes up
    mem_fwd_next = mem_req && ((|mem_hit) != mem_from_card);
    mem_pf_next = mem_req && |(mem_hit & win_prefetch);
    io_valid_next = io_req;
    io_win_next = io_req ? io_hit : 2'h0;
    io_fwd_next = io_req && ((|io_hit) != io_from_card);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_valid_reg <= 1'b0;
      fwd_claim_reg <= 1'b0;
      fwd_type0_reg <= 1'b0;
      fwd_own_reg <= 1'b0;
      mem_valid_reg <= 1'b0;
      mem_fwd_reg <= 1'b0;
      mem_win_reg <= 2'h0;
      mem_pf_reg <= 1'b0;
      io_valid_reg <= 1'b0;
      io_fwd_reg <= 1'b0;
      io_win_reg <= 2'h0;
    end else begin
      fwd_valid_reg <= fwd_valid_next;
      fwd_claim_reg <= fwd_claim_next;
      fwd_type0_reg <= fwd_type0_next;
      fwd_own_reg <= fwd_own_next;
      mem_valid_reg <= mem_valid_next;
      mem_fwd_reg <= mem_fwd_next;
      mem_win_reg <= mem_win_next;
      mem_pf_reg <= mem_pf_next;
      io_valid_reg <= io_valid_next;
      io_fwd_reg <= io_fwd_next;
      io_win_reg <= io_win_next;
    end
  end

  assign fwd_valid = fwd_valid_reg;
  assign fwd_claim = fwd_claim_reg;
  assign fwd_type0 = fwd_type0_reg;
  assign fwd_own_bus = fwd_own_reg;
  assign mem_valid = mem_valid_reg;
  assign mem_forward = mem_fwd_reg;
  assign mem_win = mem_win_reg;
  assign mem_prefetch = mem_pf_reg;
  assign io_valid = io_valid_reg;
  assign io_forward = io_fwd_reg;
  assign io_win = io_win_reg;

  // card_latency_timer
  cbw_lat_state_t lat_state_reg, lat_state_next;
  logic [LAT_W-1:0] lat_cnt_reg, lat_cnt_next;
  logic expired_reg, expired_next;
  logic term_reg, term_next;

  always_comb begin
    lat_state_next = lat_state_reg;
    lat_cnt_next = lat_cnt_reg;
    term_next = 1'b0;
    unique case (lat_state_reg)
      LAT_IDLE: begin
        if (cb_frame_start) begin
          lat_cnt_next = lat_reg;
          lat_state_next = (lat_reg == '0) ? LAT_EXPIRED : LAT_COUNT;
        end
      end
      LAT_COUNT: begin
        if (!cb_busy) begin
          lat_state_next = LAT_IDLE;
        end else if (cb_tick) begin
          lat_cnt_next = lat_cnt_reg - LAT_W'(1);
          if (lat_cnt_reg == LAT_W'(1)) begin
            lat_state_next = LAT_EXPIRED;
          end
        end
      end
      LAT_EXPIRED: begin
        if (!cb_busy) begin
          lat_state_next = LAT_IDLE;
        end else if (cb_data_done) begin
          term_next = 1'b1;
          lat_state_next = LAT_IDLE;
        end
      end
    endcase
    expired_next = (lat_state_next == LAT_EXPIRED);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_state_reg <= LAT_IDLE;
      lat_cnt_reg <= '0;
      expired_reg <= 1'b0;
      term_reg <= 1'b0;
    end else begin
      lat_state_reg <= lat_state_next;
      lat_cnt_reg <= lat_cnt_next;
      expired_reg <= expired_next;
      term_reg <= term_next;
    end
  end

  assign cb_lat_expired = expired_reg;
  assign cb_terminate = term_reg;
endmodule
`default_nettype wire

// [dv/cbw_card_model.sv]
// card-side model of the bridge's own cardbus transaction
`timescale 1ns/1ps
`default_nettype none
module cbw_card_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // bench control
  input wire logic start,
  input wire logic [7:0] phases,
  // bridge side
  input wire logic cb_terminate,
  output logic cb_frame_start,
  output logic cb_busy,
  output logic cb_data_done,
  output logic cb_tick
);
  logic [1:0] cnt;
  logic [7:0] left;
  // card clock stands still outside frames
  assign cb_tick = cb_busy;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cb_frame_start <= 1'b0;
      cb_busy <= 1'b0;
      cb_data_done <= 1'b0;
      cnt <= 2'h0;
      left <= 8'h00;
    end else begin
      cb_frame_start <= start && !cb_busy;
      cb_data_done <= cb_busy && cnt == 2'h3;
      cnt <= cb_busy ? cnt + 2'h1 : 2'h0;
      if (start && !cb_busy) begin
        cb_busy <= 1'b1;
        left <= phases;
      end else if (cb_terminate || (cb_data_done && left == 8'h01)) begin
        cb_busy <= 1'b0;
      end else if (cb_data_done) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/cbw_checker.sv]
// concurrent checks on the window decode ports
`timescale 1ns/1ps
`default_nettype none
module cbw_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // requests and answers
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic fwd_req,
  input wire logic fwd_valid,
  input wire logic fwd_claim,
  input wire logic fwd_type0,
  input wire logic fwd_own_bus,
  input wire logic mem_req,
  input wire logic mem_from_card,
  input wire logic mem_valid,
  input wire logic mem_forward,
  input wire logic [1:0] mem_win,
  input wire logic mem_prefetch,
  input wire logic io_from_card,
  input wire logic io_valid,
  input wire logic io_forward,
  input wire logic [1:0] io_win,
  // latency timer
  input wire logic cb_data_done,
  input wire logic cb_lat_expired,
  input wire logic cb_terminate
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_rd_answer: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read not answered");
  a_fwd_answer: assert property (fwd_valid == $past(fwd_req))
    else $error("forward verdict mistimed");
  a_claim_own: assert property (fwd_claim |-> fwd_valid && !fwd_own_bus)
    else $error("claim on own bus");
  a_type0_claim: assert property (fwd_type0 |-> fwd_claim)
    else $error("type 0 without claim");
  a_mem_answer: assert property (mem_req |=> mem_valid)
    else $error("memory verdict missing");
  a_mem_dir: assert property (mem_valid |-> mem_forward ==
    ($past(mem_from_card) ^ (mem_win != 2'h0))) else $error("memory direction wrong");
  a_io_dir: assert property (io_valid |-> io_forward ==
    ($past(io_from_card) ^ (io_win != 2'h0))) else $error("io direction wrong");
  a_prefetch_hit: assert property (mem_prefetch |-> mem_win != 2'h0)
    else $error("prefetch without hit");
  a_term_cause: assert property (cb_terminate |-> $past(cb_data_done) &&
    $past(cb_lat_expired)) else $error("terminate without cause");
  a_term_pulse: assert property (cb_terminate |=> !cb_terminate && !cb_lat_expired)
    else $error("terminate not a pulse");
endmodule
`default_nettype wire
bind cbw_window_decode cbw_checker u_chk (.core_clk, .reset_n, .cfg_rd, .cfg_rvalid,
  .fwd_req, .fwd_valid, .fwd_claim, .fwd_type0, .fwd_own_bus, .mem_req, .mem_from_card,
  .mem_valid, .mem_forward, .mem_win, .mem_prefetch, .io_from_card, .io_valid,
  .io_forward, .io_win, .cb_data_done, .cb_lat_expired, .cb_terminate);

// [dv/tb.sv]
// self-checking bench for the cardbus window decode
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 0, reset_n = 0, cfg_wr = 0, cfg_rd = 0, fwd_req = 0, start = 0;
  logic mem_req = 0, mem_from_card = 0, io_req = 0, io_from_card = 0, seen;
  logic io_base_sel = 0, io_limit_sel = 0, cfg_rvalid, fwd_valid, fwd_claim, fwd_type0;
  logic [7:0] cfg_addr = 0, fwd_bus = 0, phases = 0;
  logic [3:0] cfg_be = 0;
  logic [31:0] cfg_wdata = 0, mem_addr = 0, io_addr = 0, cfg_rdata;
  logic [1:0] win_prefetch = 0, mem_win, io_win;
  logic fwd_own_bus, mem_valid, mem_forward, mem_prefetch, io_valid, io_forward;
  logic cb_tick, cb_frame_start, cb_busy, cb_data_done, cb_lat_expired, cb_terminate;
  int mismatches = 0, tests_run = 0, n;
  always #12.5 core_clk = ~core_clk;
  cbw_window_decode #(.LAT_W(8)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .fwd_req(fwd_req), .fwd_bus(fwd_bus), .fwd_valid(fwd_valid),
    .fwd_claim(fwd_claim), .fwd_type0(fwd_type0), .fwd_own_bus(fwd_own_bus),
    .mem_req(mem_req), .mem_from_card(mem_from_card), .mem_addr(mem_addr),
    .mem_valid(mem_valid), .mem_forward(mem_forward), .mem_win(mem_win),
    .mem_prefetch(mem_prefetch), .io_req(io_req), .io_from_card(io_from_card),
    .io_addr(io_addr), .io_valid(io_valid), .io_forward(io_forward), .io_win(io_win),
    .win_prefetch(win_prefetch), .io_base_sel(io_base_sel), .io_limit_sel(io_limit_sel),
    .cb_tick(cb_tick), .cb_frame_start(cb_frame_start), .cb_busy(cb_busy),
    .cb_data_done(cb_data_done), .cb_lat_expired(cb_lat_expired),
    .cb_terminate(cb_terminate)
  );
  cbw_card_model u_card (
    .core_clk(core_clk), .reset_n(reset_n), .start(start), .phases(phases),
    .cb_terminate(cb_terminate), .cb_frame_start(cb_frame_start), .cb_busy(cb_busy),
    .cb_data_done(cb_data_done), .cb_tick(cb_tick)
  );
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    step();
    cfg_wr = 1'b0;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    cfg_rd = 1'b1;
    cfg_addr = a;
    step();
    cfg_rd = 1'b0;
    chk(nm, cfg_rdata, e);
    chk("rvalid", {31'h0, cfg_rvalid}, 32'h1);
    step();
    chk("rd_idle", cfg_rdata | {31'h0, cfg_rvalid}, 32'h0);
  endtask
  task automatic fwd(input logic [7:0] b, input logic [2:0] e);
    fwd_req = 1'b1;
    fwd_bus = b;
    step();
    fwd_req = 1'b0;
    chk("fwd", {28'h0, fwd_valid, fwd_claim, fwd_type0, fwd_own_bus}, {28'h0, 1'b1, e});
    step();
  endtask
  task automatic mem(input logic fc, input logic [31:0] a, input logic [1:0] pf,
      input logic [3:0] e);
    mem_req = 1'b1;
    mem_from_card = fc;
    mem_addr = a;
    win_prefetch = pf;
    step();
    mem_req = 1'b0;
    chk("mem", {27'h0, mem_valid, mem_forward, mem_prefetch, mem_win}, {27'h0, 1'b1, e});
    step();
  endtask
  task automatic io(input logic fc, input logic [31:0] a, input logic [2:0] e);
    io_req = 1'b1;
    io_from_card = fc;
    io_addr = a;
    step();
    io_req = 1'b0;
    chk("io", {28'h0, io_valid, io_forward, io_win}, {28'h0, 1'b1, e});
    step();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    rd(8'h18, 32'h0, "bus_reset");
    for (int i = 0; i < 8; i++) rd(8'h1C + 8'(4 * i), 32'h0, "win_reset");
    $display("test reset_values done");
    wr(8'h18, 4'hF, 32'h20050301);
    rd(8'h18, 32'h20050301, "bus");
    wr(8'h18, 4'h2, 32'hFFFF7FFF);
    rd(8'h18, 32'h20057F01, "sec_lane");
    wr(8'h18, 4'h2, 32'h00000300);
    fwd(8'h01, 3'b001);
    fwd(8'h03, 3'b110);
    fwd(8'h05, 3'b100);
    fwd(8'h06, 3'b000);
    fwd(8'h02, 3'b000);
    $display("test bus_numbers done");
    wr(8'h1C, 4'hF, 32'h12345FFF);
    rd(8'h1C, 32'h12345000, "mem_base0");
    wr(8'h20, 4'hF, 32'h12347ABC);
    rd(8'h20, 32'h12347000, "mem_limit0");
    mem(1'b0, 32'h12345000, 2'b01, 4'b1101);
    mem(1'b0, 32'h12347FFF, 2'b10, 4'b1001);
    mem(1'b0, 32'h12348000, 2'b01, 4'b0000);
    mem(1'b0, 32'h12344FFF, 2'b01, 4'b0000);
    mem(1'b1, 32'h12346000, 2'b01, 4'b0101);
    mem(1'b1, 32'h00000000, 2'b11, 4'b1000);
    mem(1'b0, 32'h00000000, 2'b11, 4'b0000);
    wr(8'h28, 4'hF, 32'h00001000);
    mem(1'b0, 32'h00000000, 2'b10, 4'b1110);
    $display("test memory_windows done");
    io_base_sel = 1'b1;
    io_limit_sel = 1'b1;
    wr(8'h2C, 4'hF, 32'hFFFF1237);
    rd(8'h2C, 32'h00001235, "io_base0");
    wr(8'h30, 4'hF, 32'hABCD12FF);
    rd(8'h30, 32'h000012FD, "io_limit0");
    rd(8'h34, 32'h00000001, "io_base1");
    io(1'b0, 32'h00001234, 3'b101);
    io(1'b0, 32'h000012FF, 3'b101);
    io(1'b0, 32'h00001300, 3'b000);
    io(1'b0, 32'h00001233, 3'b000);
    io(1'b0, 32'h00011234, 3'b000);
    io(1'b1, 32'h00001300, 3'b100);
    io(1'b0, 32'h00000000, 3'b000);
    wr(8'h3C, 4'hF, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, "unmapped");
    $display("test io_windows done");
    phases = 8'hFF;
    start = 1'b1;
    step();
    start = 1'b0;
    n = 0;
    while (cb_lat_expired !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    chk("lat_span", {31'h0, n inside {[32:34]}}, 32'h1);
    n = 0;
    while (cb_terminate !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    chk("term_seen", {31'h0, n < 8}, 32'h1);
    step();
    step();
    chk("term_end", {30'h0, cb_busy, cb_lat_expired}, 32'h0);
    phases = 8'h02;
    start = 1'b1;
    step();
    start = 1'b0;
    seen = 1'b0;
    n = 0;
    while (cb_busy === 1'b1 && n < 40) begin
      seen = seen | cb_lat_expired;
      step();
      n++;
    end
    chk("short_run", {31'h0, seen}, 32'h0);
    $display("test latency_timer done");
    reset_n = 1'b0;
    step();
    step();
    reset_n = 1'b1;
    rd(8'h18, 32'h0, "bus_rereset");
    rd(8'h20, 32'h0, "lim_rereset");
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
